// file: logic/audio_clock_error_monitor.sv
`timescale 1ns/1ps
module audio_clock_error_monitor #(
  parameter int STOP_CYCLES = clk_mon_pkg::STOP_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic     [13:0] second_port_ratio,
  input  wire logic       fs_clk_ratio_bad,
  input  wire logic       rc_ratio_bad,
  input  wire logic       rc_custom_mode,
  input  wire logic       em_rate_bad,
  input  wire logic       pdm_gen_bad,
  input  wire logic       audio_clk_alive,
  input  wire logic       p1_bclk_ratio_bad,
  input  wire logic       p2_bclk_ratio_bad,
  input  wire logic       core_fs_ratio_bad,
  input  wire logic       p1_fs_change,
  input  wire logic       p2_fs_change,
  input  wire logic [5:0] p1_rate_code
);
  import clk_mon_pkg::*;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // one compare shared by the write strobes and the read select
  function automatic logic addr_hit(input logic [7:0] addr,
                                    input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction

  logic sel_high;
  logic sel_low;
  logic sel_err_a;
  logic sel_err_b;
  logic sel_det_a;

  assign sel_high  = addr_hit(reg_addr, ADDR_RATIO_HIGH);
  assign sel_low   = addr_hit(reg_addr, ADDR_RATIO_LOW);
  assign sel_err_a = addr_hit(reg_addr, ADDR_ERR_A);
  assign sel_err_b = addr_hit(reg_addr, ADDR_ERR_B);
  assign sel_det_a = addr_hit(reg_addr, ADDR_DET_A);

  // ---------------------------------------------------------------
  // input synchronisers (detectors may sit in other clock domains)
  // ---------------------------------------------------------------
  logic [16:0] raw_in;
  logic [16:0] sync1_reg;
  logic [16:0] sync2_reg;
  assign raw_in = {p1_rate_code,
                   fs_clk_ratio_bad,
                   rc_ratio_bad,
                   rc_custom_mode,
                   em_rate_bad,
                   pdm_gen_bad,
                   audio_clk_alive,
                   p1_bclk_ratio_bad,
                   p2_bclk_ratio_bad,
                   core_fs_ratio_bad,
                   p1_fs_change,
                   p2_fs_change};

  // first stage may go metastable, so only the second stage reads it
  always_ff @(posedge sys_clk) begin
    if (sys_rst) sync1_reg <= '0;
    else sync1_reg <= raw_in;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) sync2_reg <= '0;
    else sync2_reg <= sync1_reg;
  end

  // rate code bits are quasi-static; a mid-change sample can mix codes
  logic [5:0] s_rate;
  logic       s_fs;
  logic       s_rc;
  logic       s_custom;
  logic       s_em;
  logic       s_pdm;
  logic       s_alive;
  logic       s_p1;
  logic       s_p2;
  logic       s_core;
  logic       s_f1;
  logic       s_f2;

  assign s_rate   = sync2_reg[16:11];
  assign s_fs     = sync2_reg[10];
  assign s_rc     = sync2_reg[9];
  assign s_custom = sync2_reg[8];
  assign s_em     = sync2_reg[7];
  assign s_pdm    = sync2_reg[6];
  assign s_alive  = sync2_reg[5];
  assign s_p1     = sync2_reg[4];
  assign s_p2     = sync2_reg[3];
  assign s_core   = sync2_reg[2];
  assign s_f1     = sync2_reg[1];
  assign s_f2     = sync2_reg[0];

  // ---------------------------------------------------------------
  // audio clock stop timer
  // ---------------------------------------------------------------
  logic clk_stopped;
  clk_stop_timer #(
    .STOP_CYCLES (STOP_CYCLES)
  ) u_stop (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .clk_alive (s_alive),
    .stopped   (clk_stopped)
  );

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  logic [7:0] err_a_next;
  logic [7:0] err_b_next;
  logic [7:0] det_a_next;
  logic [7:0] err_a_reg;
  logic [7:0] err_b_reg;
  logic [7:0] det_a_reg;
  logic       rc_flag;

  // converter check means nothing under a custom m/n setting
  assign rc_flag = s_rc && !s_custom;

  always_comb begin
    err_a_next                 = RESET_BYTE;
    err_a_next[ERR_A_FS_BIT]   = s_fs;
    err_a_next[ERR_A_RC_BIT]   = rc_flag;
    err_a_next[ERR_A_EM_BIT]   = s_em;
    err_a_next[ERR_A_PDM_BIT]  = s_pdm;
    err_a_next[ERR_A_STOP_BIT] = clk_stopped;
  end

  always_comb begin
    err_b_next                 = RESET_BYTE;
    err_b_next[ERR_B_P1_BIT]   = s_p1;
    err_b_next[ERR_B_P2_BIT]   = s_p2;
    err_b_next[ERR_B_CORE_BIT] = s_core;
    err_b_next[ERR_B_F1_BIT]   = s_f1;
    err_b_next[ERR_B_F2_BIT]   = s_f2;
  end

  always_comb begin
    det_a_next                 = RESET_BYTE;
    det_a_next[7:DET_RATE_LSB] = s_rate;
  end

  // flags are levels; bus writes never touch them
  always_ff @(posedge sys_clk) begin
    if (sys_rst) err_a_reg <= RESET_BYTE;
    else err_a_reg <= err_a_next;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) err_b_reg <= RESET_BYTE;
    else err_b_reg <= err_b_next;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) det_a_reg <= RESET_BYTE;
    else det_a_reg <= det_a_next;
  end

  // ---------------------------------------------------------------
  // ratio registers
  // ---------------------------------------------------------------
  logic [7:0] ratio_low_reg;
  logic [5:0] ratio_high_reg;
  logic       wr_low;
  logic       wr_high;

  assign wr_low  = reg_wr && sel_low;
  assign wr_high = reg_wr && sel_high;

  // upper two bits of the high register are not held here; read as zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) ratio_low_reg <= RESET_BYTE;
    else if (wr_low) ratio_low_reg <= reg_wdata;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) ratio_high_reg <= RESET_HIGH;
    else if (wr_high) ratio_high_reg <= reg_wdata[5:0];
  end

  // registered one cycle later; the ratio consumer sees each byte write on its own
  always_ff @(posedge sys_clk) begin
    if (sys_rst) second_port_ratio <= '0;
    else second_port_ratio <= {ratio_high_reg, ratio_low_reg};
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  logic [7:0] high_view;
  logic [7:0] low_view;
  logic [7:0] err_a_view;
  logic [7:0] err_b_view;
  logic [7:0] det_a_view;
  logic [7:0] rd_next;

  assign high_view  = sel_high  ? {2'h0, ratio_high_reg} : RESET_BYTE;
  assign low_view   = sel_low   ? ratio_low_reg : RESET_BYTE;
  assign err_a_view = sel_err_a ? err_a_reg : RESET_BYTE;
  assign err_b_view = sel_err_b ? err_b_reg : RESET_BYTE;
  assign det_a_view = sel_det_a ? det_a_reg : RESET_BYTE;

  // selects are one-hot, so an or of the views is the mux
  assign rd_next = high_view | low_view | err_a_view | err_b_view |
                   det_a_view;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) reg_rdata <= RESET_BYTE;
    else reg_rdata <= rd_next;
  end
endmodule // audio_clock_error_monitor

// file: logic/clk_mon_pkg.sv
// Summary of operation
// - low eight bits of second port ratio come from read/write byte, reset zero
// - second port ratio is six-bit upper field concatenated above low byte
// - error status a bit 7 set on frame sync ratio error, either port
// - bit 4 flags unsupported rate converter ratio, ignored in custom m/n mode
// - error status a bit 3 flags invalid element matching rate
// - error status a bit 2 flags invalid density clock generation
// - error status a bit 1 set once audio clock stopped one millisecond
// - error status b bit 7 flags first port bit clock ratio error
// - error status b bit 6 flags second port bit clock ratio error
// - error status b bit 5 flags core clock to frame ratio error
// - error status b bit 4 flags first port frame rate change or halt
// - error status b bit 3 flags second port frame rate change or halt
// - detect status bits 7-2 report first port detected rate code
package clk_mon_pkg;
  localparam logic [7:0] ADDR_RATIO_HIGH  = 8'h3A;
  localparam logic [7:0] ADDR_RATIO_LOW   = 8'h3B;
  localparam logic [7:0] ADDR_ERR_A       = 8'h3C;
  localparam logic [7:0] ADDR_ERR_B       = 8'h3D;
  localparam logic [7:0] ADDR_DET_A       = 8'h3E;
  localparam logic [7:0] RESET_BYTE       = 8'h00;
  localparam logic [5:0] RESET_HIGH       = 6'h00;
  localparam int         ERR_A_FS_BIT     = 7;
  localparam int         ERR_A_RC_BIT     = 4;
  localparam int         ERR_A_EM_BIT     = 3;
  localparam int         ERR_A_PDM_BIT    = 2;
  localparam int         ERR_A_STOP_BIT   = 1;
  localparam int         ERR_B_P1_BIT     = 7;
  localparam int         ERR_B_P2_BIT     = 6;
  localparam int         ERR_B_CORE_BIT   = 5;
  localparam int         ERR_B_F1_BIT     = 4;
  localparam int         ERR_B_F2_BIT     = 3;
  localparam int         DET_RATE_LSB     = 2;
  localparam int         CLK_MHZ          = 200;
  localparam int         STOP_TIME_US     = 1000;
  localparam int         STOP_CYCLES      = STOP_TIME_US * CLK_MHZ;
  localparam int         STOP_CNT_W       = 18;
endpackage : clk_mon_pkg

// file: logic/clk_stop_timer.sv
`timescale 1ns/1ps
module clk_stop_timer #(
  parameter int STOP_CYCLES = clk_mon_pkg::STOP_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic clk_alive,
  output logic      stopped
);
  import clk_mon_pkg::*;
  logic [STOP_CNT_W-1:0] cnt_reg;
  wire                   at_limit = (cnt_reg >= STOP_CNT_W'(STOP_CYCLES - 1));
  // ---------------------------------------------------------------
  // stop timer
  // ---------------------------------------------------------------
  // counter saturates so a long stop never wraps back to "running"
  always_ff @(posedge sys_clk) begin
    if (sys_rst || clk_alive) begin
      cnt_reg <= '0;
      stopped <= 1'b0;
    end else begin
      if (!at_limit) cnt_reg <= cnt_reg + 1'b1;
      stopped <= at_limit;
    end
  end
endmodule // clk_stop_timer

// file: sim/audio_clock_error_monitor_tb.sv
`timescale 1ns/1ps
module audio_clock_error_monitor_tb;
  import clk_mon_pkg::*;
  logic sys_clk = 0, sys_rst = 1, reg_wr = 0, alive = 1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [13:0] ratio;
  logic [9:0] det = 10'h000;
  logic [5:0] code = 6'h00;
  logic fs, rc, cust, em, pdm, p1, p2, core, f1, f2;
  int num_errors = 0, total_checks = 0, cyc = 0;
  // {detector command, status a, status b}
  logic [27:0] rows [11] = '{28'h2008000, 28'h1001000, 28'h1800000,
    28'h0400800, 28'h0200400, 28'h0100080, 28'h0080040, 28'h0040020,
    28'h0020010, 28'h0010008, 28'h37F9CF8};
  det_source det_source_i (.cmd(det), .fs(fs), .rc(rc), .cust(cust),
    .em(em), .pdm(pdm), .p1(p1), .p2(p2), .core(core), .f1(f1), .f2(f2));
  audio_clock_error_monitor #(.STOP_CYCLES(20)) audio_clock_error_monitor_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .second_port_ratio(ratio), .fs_clk_ratio_bad(fs), .rc_ratio_bad(rc),
    .rc_custom_mode(cust), .em_rate_bad(em), .pdm_gen_bad(pdm),
    .audio_clk_alive(alive), .p1_bclk_ratio_bad(p1),
    .p2_bclk_ratio_bad(p2), .core_fs_ratio_bad(core), .p1_fs_change(f1),
    .p2_fs_change(f2), .p1_rate_code(code));
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [13:0] got, input logic [13:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // write leaves the strobe up so writes may run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk) reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge sys_clk) reg_wr = 1'b0;
    reg_addr = a;
    repeat (6) @(negedge sys_clk);
    check({6'h00, reg_rdata}, {6'h00, e});
  endtask
  initial begin
    repeat (5) @(negedge sys_clk);
    sys_rst = 1'b0;
    rd(ADDR_RATIO_LOW, RESET_BYTE);
    rd(ADDR_ERR_B, RESET_BYTE);
    foreach (rows[i]) begin
      det = rows[i][25:16];
      rd(ADDR_ERR_A, rows[i][15:8]);
      rd(ADDR_ERR_B, rows[i][7:0]);
    end
    det = 10'h000;
    wr(ADDR_ERR_A, 8'hFF);
    wr(ADDR_RATIO_HIGH, 8'h3F); // upper reserved bits written as zero
    rd(ADDR_RATIO_HIGH, 8'h3F);
    wr(ADDR_RATIO_LOW, 8'hA5);
    rd(ADDR_RATIO_LOW, 8'hA5);
    check(ratio, 14'h3FA5);
    rd(ADDR_ERR_A, 8'h00);
    rd(8'h00, 8'h00);
    code = 6'h2A;
    rd(ADDR_DET_A, 8'hA8);
    alive = 1'b0;
    rd(ADDR_ERR_A, 8'h00);
    repeat (20) @(negedge sys_clk);
    rd(ADDR_ERR_A, 8'h02);
    alive = 1'b1;
    rd(ADDR_ERR_A, 8'h00);
    @(negedge sys_clk) sys_rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    rd(ADDR_RATIO_LOW, RESET_BYTE);
    check(ratio, 14'h0000);
    end_of_test();
  end
endmodule // audio_clock_error_monitor_tb

// file: sim/clk_mon_monitor.sv
`timescale 1ns/1ps
module clk_mon_monitor
  import clk_mon_pkg::*;
#(parameter int STOP_CYCLES = 20) (
  input wire logic sys_clk, sys_rst, reg_wr, audio_clk_alive,
  input wire logic fs_clk_ratio_bad, rc_ratio_bad, rc_custom_mode,
  input wire logic p1_bclk_ratio_bad, em_rate_bad, pdm_gen_bad,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic [5:0] p1_rate_code,
  input wire logic [13:0] second_port_ratio
);
  // low-time counter; the flag is only checked well past the limit
  int unsigned lo_cnt;
  always_ff @(posedge sys_clk) begin
    lo_cnt <= (sys_rst || audio_clk_alive) ? 0 : lo_cnt + 1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  AST_LOW_WR: assert property (reg_wr && reg_addr == ADDR_RATIO_LOW ##1
    !reg_wr [*3] |=> second_port_ratio[7:0] == $past(reg_wdata, 4))
    else $error("ratio low byte not taken");
  AST_HIGH_WR: assert property (reg_wr && reg_addr == ADDR_RATIO_HIGH ##1
    !reg_wr [*3] |=> second_port_ratio[13:8] == $past(reg_wdata[5:0], 4))
    else $error("ratio high field not taken");
  AST_FS: assert property ((reg_addr == ADDR_ERR_A && fs_clk_ratio_bad)
    [*6] |=> reg_rdata[ERR_A_FS_BIT]) else $error("frame ratio flag low");
  AST_CUSTOM: assert property ((reg_addr == ADDR_ERR_A && rc_ratio_bad &&
    rc_custom_mode) [*6] |=> !reg_rdata[ERR_A_RC_BIT])
    else $error("converter flag set in custom mode");
  AST_STOP: assert property (reg_addr == ADDR_ERR_A &&
    $past(reg_addr) == ADDR_ERR_A && lo_cnt > STOP_CYCLES + 8
    |-> reg_rdata[ERR_A_STOP_BIT]) else $error("clock stop flag low");
  AST_P1: assert property ((reg_addr == ADDR_ERR_B && p1_bclk_ratio_bad)
    [*6] |=> reg_rdata[ERR_B_P1_BIT]) else $error("port ratio flag low");
  AST_RATE: assert property ((reg_addr == ADDR_DET_A &&
    $stable(p1_rate_code)) [*6] |=> reg_rdata == {p1_rate_code, 2'b00})
    else $error("rate code mismatch");
  AST_CLEAR: assert property ((reg_addr == ADDR_ERR_A && !fs_clk_ratio_bad
    && !rc_ratio_bad && !em_rate_bad && !pdm_gen_bad && audio_clk_alive)
    [*6] |=> reg_rdata == 8'h00) else $error("idle status not zero");
  AST_UNMAPPED: assert property (reg_addr == 8'h00 |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule // clk_mon_monitor
bind audio_clock_error_monitor clk_mon_monitor
  #(.STOP_CYCLES(STOP_CYCLES)) mon_i (.*);

// file: sim/det_source.sv
`timescale 1ns/1ps
module det_source (
  input  wire logic [9:0] cmd,
  output logic            fs, rc, cust, em, pdm,
  output logic            p1, p2, core, f1, f2
);
  // detector levels held steady, as the real clock checkers give them
  assign {fs, rc, cust, em, pdm, p1, p2, core, f1, f2} = cmd;
endmodule // det_source
